// File: src/adc_setup_regs.svh
// What this block does
// [R1] Selector 0001 bandgap, 0010 small amp, 0011 large amp, against ground.
// [R2] Selector 1000 positive sensor pin, 1001 negative sensor pin, against ground.
// [R3] Selector 0100 supply, 0101 ground, 0110/0111 DAC via small/large amp.
// [R4] Selectors 0100 to 0111 force fixed 0.7 gain, overriding gain code.
// [R5] Software measuring supply should use external or bandgap reference.
// [R6] Setup A bits 15..11 hold the five-bit gain code.
// [R7] Setup A bits 10..8 hold the conversion clock divisor code.
// [R8] Setup A bits 6..4 hold resolution code; bit 7 unused.
// [R9] Setup A bit 3 offset sign, bits 2..0 offset magnitude.
// [R10] Setup B bits 6..4 hold bias code; bits 15..7 unused.
// [R11] Channel setup B bits 1..0 select reference; temperature has none.
// [R12] Gain codes 00000 to 11110 decoded; odd codes above 01000 and 10010, 10110, 11010 absent.
// [R13] Conversion clock is system clock divided by 4 doubling to 512.
// [R14] Resolution codes 000..110 take 256 to 2048 conversion clocks.
// [R15] Start bit launches conversion, halts CPU, stores result, self-clears.
// [R16] Nonzero selector makes channel conversion single-ended into its result.
// [R17] Temperature start with nonzero selector does not convert.
// [R18] Resolution 111 and undefined gains map to the next lower defined setting.
`ifndef ADC_SETUP_REGS_SVH
`define ADC_SETUP_REGS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define IDX_CONTROL 6'h00
`define IDX_DATA_1 6'h01
`define IDX_CH1_A 6'h02
`define IDX_CH1_B 6'h03
`define IDX_DATA_2 6'h04
`define IDX_CH2_A 6'h05
`define IDX_CH2_B 6'h06
`define IDX_DATA_T 6'h07
`define IDX_TEMP_A 6'h08
`define IDX_TEMP_B 6'h09

// ****************************************
// Field positions
// ****************************************
`define SRC_HI 11
`define SRC_LO 8
`define START_CH1_BIT 2
`define START_CH2_BIT 1
`define START_TEMP_BIT 0
`define GAIN_HI 15
`define GAIN_LO 11
`define DIV_HI 10
`define DIV_LO 8
`define RES_HI 6
`define RES_LO 4
`define OFS_HI 3
`define OFS_LO 0
`define BIAS_HI 6
`define BIAS_LO 4
`define REF_HI 1
`define REF_LO 0

// ****************************************
// Reset values and writable masks
// ****************************************
`define RST_CONTROL 16'h0000
`define RST_DATA 16'h0000
`define RST_SETUP_A 16'h0000
`define RST_SETUP_B 16'h0070
`define MASK_CONTROL 16'h0F07
`define MASK_SETUP_A 16'hFF7F
`define MASK_CHAN_B 16'h0073
`define MASK_TEMP_B 16'h0070
`define REF_TEMP_DEFAULT 2'h0

// ****************************************
// Gain, resolution and timing counts
// ****************************************
`define GAIN_UNITY 5'h00
`define GAIN_STEP_LIMIT 5'h08
`define GAIN_MAX 5'h1E
`define RES_MAX 3'h6
`define DIV_BASE_HALF 9'h002
`define CLKS_RES_9 12'h100
`define CLKS_RES_10 12'h140
`define CLKS_RES_12 12'h200
`define CLKS_RES_13 12'h280
`define CLKS_RES_14 12'h320
`define CLKS_RES_15 12'h500
`define CLKS_RES_16 12'h800

`endif

// File: src/adc_setup_pkg.sv
package adc_setup_pkg;

  typedef enum logic [3:0] {
    SRC_DIFF = 4'h0,
    SRC_BANDGAP = 4'h1,
    SRC_SMALL_AMP = 4'h2,
    SRC_LARGE_AMP = 4'h3,
    SRC_SUPPLY = 4'h4,
    SRC_GROUND = 4'h5,
    SRC_DAC_SMALL = 4'h6,
    SRC_DAC_LARGE = 4'h7,
    SRC_POS_IN = 4'h8,
    SRC_NEG_IN = 4'h9
  } src_sel_t;

  typedef enum logic [1:0] {
    JOB_CH1 = 2'b00,
    JOB_CH2 = 2'b01,
    JOB_TEMP = 2'b10
  } job_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONVERT = 1'b1
  } conv_state_t;

endpackage

// File: src/conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
  logic start;
  logic [2:0] div_code;
  logic [11:0] clk_count;
  logic done;
  logic conv_clk;
  modport ctrl (output start, output div_code, output clk_count,
    input done, input conv_clk);
  modport timer (input start, input div_code, input clk_count,
    output done, output conv_clk);
endinterface
`default_nettype wire

// File: src/conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_setup_regs.svh"
module conv_timer
  import adc_setup_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  conv_if.timer cv
);

  typedef struct packed {
    logic running;
    logic [8:0] half_cnt;
    logic [11:0] clk_cnt;
    logic conv_clk;
    logic done;
  } timer_t;

  timer_t q;
  timer_t d;
  logic [8:0] half;

  assign cv.done = q.done;
  assign cv.conv_clk = q.conv_clk;

  always_comb begin
    d = q;
    d.done = 1'b0;
    half = 9'(`DIV_BASE_HALF << cv.div_code); // see [R13]
    if (!q.running) begin
      if (cv.start) begin
        d.running = 1'b1;
        d.half_cnt = 9'h000;
        d.clk_cnt = 12'h000;
        d.conv_clk = 1'b0;
      end
    end else if (q.half_cnt == 9'(half - 9'h001)) begin
      d.half_cnt = 9'h000;
      d.conv_clk = ~q.conv_clk;
      if (!q.conv_clk) begin
        // Rising edge of the conversion clock
        d.clk_cnt = 12'(q.clk_cnt + 12'h001);
      end else if (q.clk_cnt == cv.clk_count) begin // see [R14]
        // Last clock finishes its high half, so no edge is swallowed
        d.done = 1'b1;
        d.running = 1'b0;
      end
    end else begin
      d.half_cnt = 9'(q.half_cnt + 9'h001);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// File: src/adc_conversion_setup.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_setup_regs.svh"
module adc_conversion_setup
  import adc_setup_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] ADC_RESULT,
  output logic [3:0] AIN_SOURCE,
  output logic [1:0] AIN_BANK,
  output logic [4:0] GAIN_CODE,
  output logic GAIN_FIXED_LOW,
  output logic [2:0] RESOLUTION_CODE,
  output logic [3:0] COARSE_OFFSET_CODE,
  output logic [2:0] BIAS_LEVEL_CODE,
  output logic [1:0] REFERENCE_SELECT,
  output logic CONV_CLK,
  output logic CPU_HALT
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    conv_state_t st;
    job_t job;
    logic [15:0] ctrl;
    logic [15:0] data_1;
    logic [15:0] ch1_a;
    logic [15:0] ch1_b;
    logic [15:0] data_2;
    logic [15:0] ch2_a;
    logic [15:0] ch2_b;
    logic [15:0] data_t;
    logic [15:0] temp_a;
    logic [15:0] temp_b;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] src;
    logic [4:0] gain;
    logic gain_fixed;
    logic [2:0] res;
    logic [3:0] ofs;
    logic [2:0] bias;
    logic [1:0] refsel;
    logic [2:0] div;
    logic [11:0] clks;
    logic start;
    logic halt;
  } state_t;

  state_t q;
  state_t d;
  conv_if cv ();

  conv_timer timer_u (
    .clk(CLK),
    .reset_n(RESET_N),
    .cv(cv.timer)
  );

  assign cv.start = q.start;
  assign cv.div_code = q.div;
  assign cv.clk_count = q.clks;

  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign AIN_SOURCE = q.src;
  assign AIN_BANK = q.job;
  assign GAIN_CODE = q.gain;
  assign GAIN_FIXED_LOW = q.gain_fixed;
  assign RESOLUTION_CODE = q.res;
  assign COARSE_OFFSET_CODE = q.ofs;
  assign BIAS_LEVEL_CODE = q.bias;
  assign REFERENCE_SELECT = q.refsel;
  assign CONV_CLK = cv.conv_clk;
  assign CPU_HALT = q.halt;

  // ****************************************
  // Decoders
  // ****************************************
  // Undefined gains fall to the next lower listed step
  function automatic logic [4:0] gain_near(input logic [4:0] c);
    if (c <= `GAIN_STEP_LIMIT) begin
      gain_near = c;
    end else if (!c[4]) begin
      gain_near = {c[4:1], 1'b0}; // see [R12]
    end else if (c >= `GAIN_MAX) begin
      gain_near = `GAIN_MAX; // see [R18]
    end else begin
      gain_near = {c[4:2], 2'b00};
    end
  endfunction

  function automatic logic [11:0] res_clks(input logic [2:0] r);
    unique case (r)
      3'h0: res_clks = `CLKS_RES_9;
      3'h1: res_clks = `CLKS_RES_10;
      3'h2: res_clks = `CLKS_RES_12;
      3'h3: res_clks = `CLKS_RES_13;
      3'h4: res_clks = `CLKS_RES_14;
      3'h5: res_clks = `CLKS_RES_15;
      default: res_clks = `CLKS_RES_16; // see [R14] [R18]
    endcase
  endfunction

  // Reserved selector codes measure ground rather than float
  function automatic logic [3:0] src_map(input logic [3:0] s);
    src_map = (s > SRC_NEG_IN) ? SRC_GROUND : s; // see [R1] [R2] [R3]
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic [5:0] idx;
  logic mapped;
  logic [15:0] rd;
  logic [15:0] set_a;
  logic [15:0] set_b;
  logic [3:0] se;
  logic launch;
  job_t pick;

  always_comb begin
    d = q;
    d.start = 1'b0;
    idx = PADDR[7:2];
    rd = 16'h0000;
    mapped = (PADDR[1:0] == 2'b00);
    unique case (idx)
      `IDX_CONTROL: rd = q.ctrl;
      `IDX_DATA_1: rd = q.data_1;
      `IDX_CH1_A: rd = q.ch1_a;
      `IDX_CH1_B: rd = q.ch1_b;
      `IDX_DATA_2: rd = q.data_2;
      `IDX_CH2_A: rd = q.ch2_a;
      `IDX_CH2_B: rd = q.ch2_b;
      `IDX_DATA_T: rd = q.data_t;
      `IDX_TEMP_A: rd = q.temp_a;
      `IDX_TEMP_B: rd = q.temp_b;
      default: mapped = 1'b0;
    endcase

    // Conversion sequencing
    se = q.ctrl[`SRC_HI:`SRC_LO];
    launch = 1'b0;
    pick = JOB_CH1;
    set_a = q.ch1_a;
    set_b = q.ch1_b;
    if (q.st == ST_IDLE) begin
      if (q.ctrl[`START_CH1_BIT]) begin
        launch = 1'b1;
      end else if (q.ctrl[`START_CH2_BIT]) begin
        launch = 1'b1;
        pick = JOB_CH2;
        set_a = q.ch2_a;
        set_b = q.ch2_b;
      end else if (q.ctrl[`START_TEMP_BIT]) begin
        if (se != SRC_DIFF) begin
          d.ctrl[`START_TEMP_BIT] = 1'b0; // see [R17]
        end else begin
          launch = 1'b1;
          pick = JOB_TEMP;
          set_a = q.temp_a;
          set_b = q.temp_b;
        end
      end
    end

    if (launch) begin
      // Settings are frozen for the whole conversion
      d.st = ST_CONVERT;
      d.job = pick;
      d.start = 1'b1;
      d.halt = 1'b1; // see [R15]
      d.src = (pick == JOB_TEMP) ? SRC_DIFF : src_map(se); // see [R16]
      d.gain = gain_near(set_a[`GAIN_HI:`GAIN_LO]); // see [R6] [R12]
      d.gain_fixed = 1'b0;
      // Mapped code, so reserved codes read ground at the fixed gain
      if (pick != JOB_TEMP && d.src[3:2] == 2'b01) begin
        d.gain = `GAIN_UNITY;
        d.gain_fixed = 1'b1; // see [R4]
      end
      if (pick != JOB_TEMP && se == SRC_BANDGAP) begin
        d.gain = `GAIN_UNITY; // see [R1]
      end
      d.div = set_a[`DIV_HI:`DIV_LO]; // see [R7]
      d.res = set_a[`RES_HI:`RES_LO]; // see [R8]
      if (d.res > `RES_MAX) begin
        d.res = `RES_MAX; // see [R18]
      end
      d.clks = res_clks(d.res);
      d.ofs = set_a[`OFS_HI:`OFS_LO]; // see [R9]
      d.bias = set_b[`BIAS_HI:`BIAS_LO]; // see [R10]
      d.refsel = (pick == JOB_TEMP) ? `REF_TEMP_DEFAULT
        : set_b[`REF_HI:`REF_LO]; // see [R11]
    end

    if (q.st == ST_CONVERT && cv.done) begin
      d.st = ST_IDLE;
      d.halt = 1'b0;
      unique case (q.job)
        JOB_CH1: begin
          d.data_1 = ADC_RESULT; // see [R15]
          d.ctrl[`START_CH1_BIT] = 1'b0;
        end
        JOB_CH2: begin
          d.data_2 = ADC_RESULT;
          d.ctrl[`START_CH2_BIT] = 1'b0;
        end
        default: begin
          d.data_t = ADC_RESULT;
          d.ctrl[`START_TEMP_BIT] = 1'b0;
        end
      endcase
    end

    // APB: answer is set up in the setup cycle, zero wait
    if (PSEL && !PENABLE) begin
      d.pready = 1'b1;
      d.pslverr = !mapped;
      d.prdata = (!PWRITE && mapped) ? {16'h0000, rd} : 32'h0000_0000;
    end else if (PSEL && PENABLE && q.pready) begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      if (PWRITE && mapped) begin
        // A write lands after any hardware clear, so a set is never lost
        unique case (idx)
          `IDX_CONTROL: d.ctrl = PWDATA[15:0] & `MASK_CONTROL;
          `IDX_CH1_A: d.ch1_a = PWDATA[15:0] & `MASK_SETUP_A;
          `IDX_CH1_B: d.ch1_b = PWDATA[15:0] & `MASK_CHAN_B;
          `IDX_CH2_A: d.ch2_a = PWDATA[15:0] & `MASK_SETUP_A;
          `IDX_CH2_B: d.ch2_b = PWDATA[15:0] & `MASK_CHAN_B;
          `IDX_TEMP_A: d.temp_a = PWDATA[15:0] & `MASK_SETUP_A;
          `IDX_TEMP_B: d.temp_b = PWDATA[15:0] & `MASK_TEMP_B;
          default: begin
          end
        endcase
      end
    end else begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.job <= JOB_CH1;
      q.ctrl <= `RST_CONTROL;
      q.data_1 <= `RST_DATA;
      q.data_2 <= `RST_DATA;
      q.data_t <= `RST_DATA;
      q.ch1_a <= `RST_SETUP_A;
      q.ch2_a <= `RST_SETUP_A;
      q.temp_a <= `RST_SETUP_A;
      q.ch1_b <= `RST_SETUP_B;
      q.ch2_b <= `RST_SETUP_B;
      q.temp_b <= `RST_SETUP_B;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// File: sim/adc_conversion_setup_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_setup_properties (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [3:0] AIN_SOURCE,
  input wire logic [1:0] AIN_BANK,
  input wire logic [4:0] GAIN_CODE,
  input wire logic GAIN_FIXED_LOW,
  input wire logic [2:0] RESOLUTION_CODE,
  input wire logic [1:0] REFERENCE_SELECT,
  input wire logic CPU_HALT
);
  // ****************************************
  // Bus and conversion properties
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_launch;
    !CPU_HALT ##1 CPU_HALT;
  endsequence
  a_ready_access: assert property (s_setup |=> PREADY)
    else $error("ready missing in access cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_fixed_gain: assert property (
    CPU_HALT && AIN_SOURCE[3:2] == 2'b01 |->
    GAIN_FIXED_LOW && GAIN_CODE == 5'h00) else $error("gain not fixed");
  a_fixed_only: assert property (
    GAIN_FIXED_LOW |-> AIN_SOURCE[3:2] == 2'b01)
    else $error("fixed gain on wrong source");
  a_temp_path: assert property (
    CPU_HALT && AIN_BANK == 2'h2 |->
    AIN_SOURCE == 4'h0 && REFERENCE_SELECT == 2'h0)
    else $error("temperature path wrong");
  a_res_defined: assert property (
    CPU_HALT |-> RESOLUTION_CODE != 3'h7) else $error("reserved resolution");
  a_gain_defined: assert property (
    CPU_HALT |-> GAIN_CODE <= 5'h1E) else $error("gain out of range");
  // Shortest conversion is far longer than eight cycles
  a_halt_hold: assert property (s_launch |-> CPU_HALT[*8])
    else $error("halt dropped early");
  a_setting_hold: assert property (
    CPU_HALT && $past(CPU_HALT) |->
    $stable(AIN_SOURCE) && $stable(GAIN_CODE) && $stable(AIN_BANK))
    else $error("settings moved in conversion");
endmodule
bind adc_conversion_setup adc_setup_properties u_adc_setup_properties (
  .CLK, .RESET_N, .PSEL, .PENABLE, .PREADY, .PSLVERR, .AIN_SOURCE,
  .AIN_BANK, .GAIN_CODE, .GAIN_FIXED_LOW, .RESOLUTION_CODE,
  .REFERENCE_SELECT, .CPU_HALT);
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, GAIN_FIXED_LOW, CONV_CLK, CPU_HALT;
  logic [15:0] ADC_RESULT = 16'h0000;
  logic [3:0] AIN_SOURCE, COARSE_OFFSET_CODE;
  logic [1:0] AIN_BANK, REFERENCE_SELECT;
  logic [4:0] GAIN_CODE;
  logic [2:0] RESOLUTION_CODE, BIAS_LEVEL_CODE;
  int err_count = 0;
  int tests_run = 0;
  int rises = 0;
  always #50 CLK = ~CLK;
  adc_conversion_setup u_adc_conversion_setup (.CLK, .RESET_N, .PADDR,
    .PSEL, .PENABLE, .PWRITE, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .ADC_RESULT, .AIN_SOURCE, .AIN_BANK, .GAIN_CODE, .GAIN_FIXED_LOW,
    .RESOLUTION_CODE, .COARSE_OFFSET_CODE, .BIAS_LEVEL_CODE,
    .REFERENCE_SELECT, .CONV_CLK, .CPU_HALT);
  // ****************************************
  // Bus tasks
  // ****************************************
  task apb(input logic w, input logic [7:0] a, input logic [15:0] d,
    output logic [31:0] r, output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {16'h0000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Only PREADY or the watchdog ends this wait
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 16'h0000, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    `CHK(e, 1'b0)
  endtask
  // Bounded waits: a stuck halt must not hang the run
  task conv(input logic [15:0] c, output int n);
    logic last;
    wr(8'h00, c);
    n = 0;
    while (CPU_HALT !== 1'b1 && n < 20) begin
      @(posedge CLK);
      n++;
    end
    n = 0;
    rises = 0;
    last = CONV_CLK;
    while (CPU_HALT === 1'b1 && n < 20000) begin
      @(posedge CLK);
      n++;
      if (CONV_CLK === 1'b1 && last !== 1'b1) begin
        rises++;
      end
      last = CONV_CLK;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    rd(8'h08, 32'h0, 1'b0);
    rd(8'h0C, 32'h70, 1'b0);
    rd(8'h24, 32'h70, 1'b0);
    wr(8'h08, 16'hFFFF);
    rd(8'h08, 32'hFF7F, 1'b0);
    wr(8'h0C, 16'hFFFF);
    rd(8'h0C, 32'h73, 1'b0);
    wr(8'h24, 16'hFFFF);
    rd(8'h24, 32'h70, 1'b0);
    wr(8'h04, 16'h1234);
    rd(8'h04, 32'h0, 1'b0);
    rd(8'h28, 32'h0, 1'b1);
    rd(8'h09, 32'h0, 1'b1);
  endtask
  task t_chan1;
    int n;
    wr(8'h08, 16'h190A);
    wr(8'h0C, 16'h0052);
    ADC_RESULT <= 16'hA5C3;
    conv(16'h0804, n);
    `CHK(AIN_SOURCE, 4'h8)
    `CHK(AIN_BANK, 2'h0)
    `CHK(GAIN_CODE, 5'h03)
    `CHK(GAIN_FIXED_LOW, 1'b0)
    `CHK(RESOLUTION_CODE, 3'h0)
    `CHK(COARSE_OFFSET_CODE, 4'hA)
    `CHK(BIAS_LEVEL_CODE, 3'h5)
    `CHK(REFERENCE_SELECT, 2'h2)
    `CHK(n >= 2040 && n <= 2056, 1'b1)
    `CHK(rises, 256)
    `CHK(CONV_CLK, 1'b0)
    rd(8'h04, 32'hA5C3, 1'b0);
    rd(8'h00, 32'h0800, 1'b0);
  endtask
  task t_sources;
    int n;
    logic [3:0] s;
    logic [3:0] x;
    logic [4:0] g;
    wr(8'h14, 16'hF000);
    wr(8'h18, 16'h0072);
    for (int i = 1; i < 11; i++) begin
      s = i[3:0];
      // Reserved code 1010 is expected to read ground
      x = (s > 4'h9) ? 4'h5 : s;
      g = (x[3:2] == 2'b01 || x == 4'h1) ? 5'h00 : 5'h1E;
      ADC_RESULT <= {12'h5A0, s};
      conv({4'h0, s, 8'h02}, n);
      `CHK(AIN_SOURCE, x)
      `CHK(AIN_BANK, 2'h1)
      `CHK(REFERENCE_SELECT, 2'h2)
      `CHK(GAIN_FIXED_LOW, x[3:2] == 2'b01)
      `CHK(GAIN_CODE, g)
      `CHK(rises, 256)
      rd(8'h10, {20'h005A0, s}, 1'b0);
    end
  endtask
  task t_temp;
    int n;
    ADC_RESULT <= 16'h3C3C;
    conv(16'h0101, n);
    `CHK(n, 0)
    rd(8'h00, 32'h0100, 1'b0);
    rd(8'h1C, 32'h0, 1'b0);
    wr(8'h20, 16'hF870);
    wr(8'h24, 16'h0030);
    conv(16'h0001, n);
    `CHK(AIN_SOURCE, 4'h0)
    `CHK(GAIN_CODE, 5'h1E)
    `CHK(RESOLUTION_CODE, 3'h6)
    `CHK(AIN_BANK, 2'h2)
    `CHK(REFERENCE_SELECT, 2'h0)
    `CHK(BIAS_LEVEL_CODE, 3'h3)
    `CHK(n >= 8188 && n <= 8200, 1'b1)
    `CHK(rises, 2048)
    rd(8'h1C, 32'h3C3C, 1'b0);
    rd(8'h00, 32'h0000, 1'b0);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    t_regs;
    t_chan1;
    t_sources;
    t_temp;
    test_done;
  end
  initial begin
    repeat (40000) @(posedge CLK);
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire
